/* signal_cmp_pkg.sv */
// What this block does
// - Analog comparator compares first input against second
// - Function select picks one of six comparisons
// - Equality window sets tolerated input difference
// - Hysteresis stops output chatter near switching point
// - Greater-than sets once first exceeds second
// - Greater-than clears below second minus hysteresis
// - Less-than sets once first drops below second
// - Less-than clears above second plus hysteresis
// - Magnitude equality is equality on magnitudes
// - Magnitude greater-than compares magnitudes with hysteresis
// - Magnitude less-than compares magnitudes with hysteresis
// - Magnitude functions strip signs before processing
// - Three phase comparators drive trigger outputs
// - Each phase comparator has own function select
// - Phase equality uses window and hysteresis
// - Phase greater-than: high while first exceeds
// - Phase less-than: high while first smaller
// - Phase magnitude functions compare absolute values
`default_nettype none
package signal_cmp_pkg;

    localparam int unsigned N_ANALOG = 3;
    localparam int unsigned N_PHASE = 3;
    localparam int unsigned N_CMP = 6;
    localparam int unsigned ANALOG_W = 16;
    localparam int unsigned PHASE_W = 32;
    localparam int unsigned CALC_W = 36;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register map
    localparam logic [7:0] CMP_BASE = 8'h00;
    localparam logic [7:0] CMP_STRIDE = 8'h10;
    localparam logic [3:0] FUNC_OFS = 4'h0;
    localparam logic [3:0] HYST_OFS = 4'h4;
    localparam logic [3:0] WIN_OFS = 4'h8;
    localparam logic [7:0] STATUS_ADDR = 8'h60;

    // Field positions
    localparam int unsigned FUNC_LSB = 0;
    localparam int unsigned FUNC_W = 3;
    localparam int unsigned STATUS_ANALOG_LSB = 0;
    localparam int unsigned STATUS_PHASE_LSB = 3;
    localparam logic [31:0] ANALOG_PARAM_MASK = 32'h0000ffff;
    localparam logic [31:0] PHASE_PARAM_MASK = 32'hffffffff;

    typedef enum logic [2:0] {
        FN_OFF,
        FN_EQ,
        FN_GT,
        FN_LT,
        FN_ABS_EQ,
        FN_ABS_GT,
        FN_ABS_LT
    } cmp_func_t;

    // Reset values
    localparam cmp_func_t FUNC_RESET = FN_OFF;
    localparam logic [31:0] HYST_RESET = 32'h00000000;
    localparam logic [31:0] WIN_RESET = 32'h00000000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        cmp_func_t func;
        logic [31:0] hyst;
        logic [31:0] win;
    } cmp_cfg_t;

endpackage
`default_nettype wire

/* signal_threshold_comparators.sv */
`timescale 1ns/1ns
`default_nettype none
module signal_threshold_comparators (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire signal_cmp_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparators
    input wire logic [2:0][15:0] analog_cmp_first_input,
    input wire logic [2:0][15:0] analog_cmp_second_input,
    output logic [2:0] analog_cmp_result,
    // Phase comparators
    input wire logic [2:0][31:0] phase_cmp_first_input,
    input wire logic [2:0][31:0] phase_cmp_second_input,
    output logic [2:0] phase_cmp_result
);

    signal_cmp_pkg::cmp_cfg_t cfg_q [signal_cmp_pkg::N_CMP];
    logic [5:0] result_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    logic setup;
    logic access;
    logic [2:0] inst;
    logic [3:0] field;
    logic hit_cfg;
    logic hit_status;
    logic [31:0] read_value;

    function automatic logic signed [35:0] mag(input logic signed [35:0] v);
        mag = v[35] ? -v : v;
    endfunction

    // Bus decode
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & pready_q;
    assign inst = apb_req.paddr[6:4];
    assign field = {apb_req.paddr[3:2], 2'b00};
    assign hit_cfg = ~apb_req.paddr[7] && (inst < 3'd6) && (field != 4'hc);
    assign hit_status = (apb_req.paddr == signal_cmp_pkg::STATUS_ADDR);

    always_comb begin
        read_value = 32'h00000000;
        if (hit_status) begin
            read_value[signal_cmp_pkg::STATUS_ANALOG_LSB +: 3] = result_q[2:0];
            read_value[signal_cmp_pkg::STATUS_PHASE_LSB +: 3] = result_q[5:3];
        end else if (hit_cfg) begin
            case (field)
                signal_cmp_pkg::FUNC_OFS: begin
                    read_value[signal_cmp_pkg::FUNC_LSB +: signal_cmp_pkg::FUNC_W] =
                        cfg_q[inst].func;
                end
                signal_cmp_pkg::HYST_OFS: begin
                    read_value = cfg_q[inst].hyst;
                end
                signal_cmp_pkg::WIN_OFS: begin
                    read_value = cfg_q[inst].win;
                end
                default: begin
                    read_value = 32'h00000000;
                end
            endcase
        end
    end

    // Answer: ready in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~(hit_cfg | hit_status);
            prdata_q <= (setup & ~apb_req.pwrite) ? read_value : 32'h00000000;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < signal_cmp_pkg::N_CMP; i++) begin
                cfg_q[i].func <= signal_cmp_pkg::FUNC_RESET;
                cfg_q[i].hyst <= signal_cmp_pkg::HYST_RESET;
                cfg_q[i].win <= signal_cmp_pkg::WIN_RESET;
            end
        end else if (access && apb_req.pwrite && hit_cfg) begin
            case (field)
                signal_cmp_pkg::FUNC_OFS: begin
                    cfg_q[inst].func <= signal_cmp_pkg::cmp_func_t'(
                        apb_req.pwdata[signal_cmp_pkg::FUNC_LSB +: signal_cmp_pkg::FUNC_W]);
                end
                signal_cmp_pkg::HYST_OFS: begin
                    cfg_q[inst].hyst <= apb_req.pwdata & ((inst < 3'd3) ?
                        signal_cmp_pkg::ANALOG_PARAM_MASK : signal_cmp_pkg::PHASE_PARAM_MASK);
                end
                signal_cmp_pkg::WIN_OFS: begin
                    cfg_q[inst].win <= apb_req.pwdata & ((inst < 3'd3) ?
                        signal_cmp_pkg::ANALOG_PARAM_MASK : signal_cmp_pkg::PHASE_PARAM_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    // One comparator per instance; 0..2 analog, 3..5 phase
    for (genvar g = 0; g < signal_cmp_pkg::N_CMP; g++) begin : g_cmp
        logic signed [35:0] in_a;
        logic signed [35:0] in_b;
        logic signed [35:0] x;
        logic signed [35:0] y;
        logic signed [35:0] abs_diff;
        logic signed [35:0] h;
        logic signed [35:0] hd;
        logic signed [35:0] w;
        logic abs_mode;
        logic nxt;

        if (g < 3) begin : g_analog
            assign in_a = 36'(signed'(analog_cmp_first_input[g]));
            assign in_b = 36'(signed'(analog_cmp_second_input[g]));
            assign hd = h;
        end else begin : g_phase
            assign in_a = 36'(signed'(phase_cmp_first_input[g-3]));
            assign in_b = 36'(signed'(phase_cmp_second_input[g-3]));
            assign hd = 36'sd0;
        end

        assign abs_mode = (cfg_q[g].func == signal_cmp_pkg::FN_ABS_EQ) ||
                          (cfg_q[g].func == signal_cmp_pkg::FN_ABS_GT) ||
                          (cfg_q[g].func == signal_cmp_pkg::FN_ABS_LT);
        assign x = abs_mode ? mag(in_a) : in_a;
        assign y = abs_mode ? mag(in_b) : in_b;
        assign abs_diff = mag(x - y);
        assign h = signed'({4'h0, cfg_q[g].hyst});
        assign w = signed'({4'h0, cfg_q[g].win});

        always_comb begin
            case (cfg_q[g].func)
                signal_cmp_pkg::FN_EQ, signal_cmp_pkg::FN_ABS_EQ: begin
                    nxt = result_q[g] ? (abs_diff <= w + h) : (abs_diff <= w);
                end
                signal_cmp_pkg::FN_GT, signal_cmp_pkg::FN_ABS_GT: begin
                    nxt = result_q[g] ? !(x < y - hd) : (x > y);
                end
                signal_cmp_pkg::FN_LT, signal_cmp_pkg::FN_ABS_LT: begin
                    nxt = result_q[g] ? !(x > y + hd) : (x < y);
                end
                default: begin
                    nxt = 1'b0;
                end
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                result_q[g] <= 1'b0;
            end else begin
                result_q[g] <= nxt;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analog_cmp_result = result_q[2:0];
    assign phase_cmp_result = result_q[5:3];

endmodule
`default_nettype wire

/* signal_cmp_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module signal_cmp_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire signal_cmp_pkg::apb_req_t apb_req,
    input wire logic pready,
    input wire logic [2:0][15:0] analog_cmp_first_input,
    input wire logic [2:0][15:0] analog_cmp_second_input,
    input wire logic [2:0] analog_cmp_result,
    input wire logic [2:0][31:0] phase_cmp_first_input,
    input wire logic [2:0][31:0] phase_cmp_second_input,
    input wire logic [2:0] phase_cmp_result
);
    logic [2:0] fa_q;
    logic [2:0] fp_q;
    logic [15:0] ha_q;
    int x;
    int y;
    logic pgt;
    logic plt;
    // Mirror of written function settings of comparators 0 and 3 and hysteresis of comparator 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fa_q <= 3'h0;
            fp_q <= 3'h0;
            ha_q <= 16'h0;
        end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && pready) begin
            if (apb_req.paddr == 8'h00) fa_q <= apb_req.pwdata[2:0];
            if (apb_req.paddr == 8'h30) fp_q <= apb_req.pwdata[2:0];
            if (apb_req.paddr == 8'h04) ha_q <= apb_req.pwdata[15:0];
        end
    end
    always_comb begin
        x = int'($signed(analog_cmp_first_input[0]));
        y = int'($signed(analog_cmp_second_input[0]));
        pgt = $signed(phase_cmp_first_input[0]) > $signed(phase_cmp_second_input[0]);
        plt = $signed(phase_cmp_first_input[0]) < $signed(phase_cmp_second_input[0]);
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence ph_gt_s; fp_q == 3'h2 && (pgt || plt); endsequence
    sequence ph_lt_s; fp_q == 3'h3 && (pgt || plt); endsequence
    gt_set_a: assert property (fa_q == 3'h2 && x > y |=> analog_cmp_result[0])
        else $error("greater-than did not set");
    gt_clear_a: assert property (fa_q == 3'h2 && x < y - int'(ha_q) |=> !analog_cmp_result[0])
        else $error("greater-than did not clear");
    lt_set_a: assert property (fa_q == 3'h3 && x < y |=> analog_cmp_result[0])
        else $error("less-than did not set");
    lt_clear_a: assert property (fa_q == 3'h3 && x > y + int'(ha_q) |=> !analog_cmp_result[0])
        else $error("less-than did not clear");
    off_zero_a: assert property (fa_q == 3'h0 || fa_q == 3'h7 |=> !analog_cmp_result[0])
        else $error("unused code gave high result");
    abs_gt_a: assert property (fa_q == 3'h5 && (x < 0 ? -x : x) > (y < 0 ? -y : y)
        |=> analog_cmp_result[0])
        else $error("magnitude greater-than did not set");
    ph_gt_a: assert property (ph_gt_s |=> phase_cmp_result[0] == $past(pgt))
        else $error("phase greater-than wrong");
    ph_lt_a: assert property (ph_lt_s |=> phase_cmp_result[0] == $past(plt))
        else $error("phase less-than wrong");
    reset_clear_a: assert property ($rose(presetn) |-> analog_cmp_result == 3'h0
        && phase_cmp_result == 3'h0)
        else $error("results not clear after reset");
endmodule
bind signal_threshold_comparators signal_cmp_properties chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .pready(pready), .analog_cmp_first_input(analog_cmp_first_input),
    .analog_cmp_second_input(analog_cmp_second_input), .analog_cmp_result(analog_cmp_result),
    .phase_cmp_first_input(phase_cmp_first_input), .phase_cmp_second_input(phase_cmp_second_input),
    .phase_cmp_result(phase_cmp_result));
`default_nettype wire

/* signal_source_model.sv */
`timescale 1ns/1ns
`default_nettype none
module signal_source_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requested levels
    input wire logic [1:0][2:0][15:0] a_set,
    input wire logic [1:0][2:0][31:0] p_set,
    // Levels toward the comparators
    output logic [1:0][2:0][15:0] a_q,
    output logic [1:0][2:0][31:0] p_q
);
    // Upstream blocks refresh once per processing cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= '0;
            p_q <= '0;
        end else begin
            a_q <= a_set;
            p_q <= p_set;
        end
    end
endmodule
`default_nettype wire

/* signal_threshold_comparators_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module signal_threshold_comparators_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    signal_cmp_pkg::apb_req_t apb_req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0][2:0][15:0] a_s = '0;
    logic [1:0][2:0][31:0] p_s = '0;
    logic [1:0][2:0][15:0] a;
    logic [1:0][2:0][31:0] p;
    logic [2:0] ares;
    logic [2:0] pres;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #10 pclk = ~pclk;
    signal_source_model src (.pclk(pclk), .presetn(presetn), .a_set(a_s), .p_set(p_s), .a_q(a),
        .p_q(p));
    signal_threshold_comparators dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_cmp_first_input(a[0]),
        .analog_cmp_second_input(a[1]), .analog_cmp_result(ares), .phase_cmp_first_input(p[0]),
        .phase_cmp_second_input(p[1]), .phase_cmp_result(pres));
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, ad, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] e, input logic ee);
        apb(1'b0, ad, 32'h0);
        check("prdata", rd, e);
        check("pslverr", {31'h0, err}, {31'h0, ee});
    endtask
    task automatic step(input logic ph, input int k, input logic [31:0] x, input logic [31:0] y,
        input logic e);
        @(posedge pclk);
        if (ph) begin
            p_s[0][k] <= x;
            p_s[1][k] <= y;
        end else begin
            a_s[0][k] <= x[15:0];
            a_s[1][k] <= y[15:0];
        end
        repeat (3) @(posedge pclk);
        check("result", {31'h0, ph ? pres[k] : ares[k]}, {31'h0, e});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h00, 32'h0, 1'b0);
        rdchk(8'h0c, 32'h0, 1'b1);
        apb(1'b1, 8'h28, 32'hffffffff);
        rdchk(8'h28, 32'h0000ffff, 1'b0);
        $display("test registers done");
        apb(1'b1, 8'h04, 32'ha);
        apb(1'b1, 8'h00, 32'h2);
        step(1'b0, 0, 32'h65, 32'h64, 1'b1);
        step(1'b0, 0, 32'h5a, 32'h64, 1'b1);
        step(1'b0, 0, 32'h59, 32'h64, 1'b0);
        apb(1'b1, 8'h00, 32'h3);
        step(1'b0, 0, 32'h59, 32'h64, 1'b1);
        step(1'b0, 0, 32'h6e, 32'h64, 1'b1);
        step(1'b0, 0, 32'h6f, 32'h64, 1'b0);
        $display("test hysteresis done");
        for (int ph = 0; ph < 2; ph++) begin
            for (int c = 1; c < 8; c++) begin
                apb(1'b1, ph ? 8'h30 : 8'h00, 32'(c));
                step(ph[0], 0, ph ? 32'h5 : 32'hffffff38, ph ? 32'hfffffff9 : 32'h64,
                    1'(16'h4428 >> (ph * 8 + c)));
            end
        end
        $display("test functions done");
        for (int ph = 0; ph < 2; ph++) begin
            apb(1'b1, ph ? 8'h48 : 8'h18, 32'h5);
            apb(1'b1, ph ? 8'h44 : 8'h14, 32'h3);
            apb(1'b1, ph ? 8'h40 : 8'h10, 32'h1);
            step(ph[0], 1, 32'hfffffffb, 32'h0, 1'b1);
            step(ph[0], 1, 32'hfffffff8, 32'h0, 1'b1);
            step(ph[0], 1, 32'hfffffff7, 32'h0, 1'b0);
            step(ph[0], 1, 32'hfffffffa, 32'h0, 1'b0);
        end
        $display("test equality done");
        apb(1'b1, 8'h30, 32'h5);
        step(1'b1, 0, 32'h80000000, 32'h7fffffff, 1'b1);
        rdchk(8'h60, 32'h8, 1'b0);
        $display("test magnitude done");
        give_verdict();
    end
endmodule
`default_nettype wire
